/* File: common/interval_timer_pkg.sv */
// Constants and register map of the 32-bit interval timer
package interval_timer_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [3:0] CTRL_OFFSET = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;
   localparam logic [3:0] COUNT_OFFSET = 4'h8;
   localparam logic [3:0] COMPARE_OFFSET = 4'hC;
   // ----------------------------------------
   // Field positions, reset values and bus response codes
   // ----------------------------------------
   localparam int IRQ_EN_BIT = 0;
   localparam int ONE_SHOT_BIT = 1;
   localparam int RUN_EN_BIT = 2;
   localparam int FLAG_BIT = 0;
   localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
   localparam logic [31:0] COMPARE_RESET = 32'hFFFF_FFFF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: common/reg_access_if.sv */
// Register access strobes between bus slave and timer core
`timescale 1ns/1ns
`default_nettype none
interface reg_access_if;
   logic wr_en;
   logic [3:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [3:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_hit;
   logic wr_hit;
   modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input rd_data, rd_hit, wr_hit);
   modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output rd_data, rd_hit, wr_hit);
endinterface
`default_nettype wire

/* File: hdl/axil_reg_slave.sv */
// AXI4-Lite slave producing register strobes
`timescale 1ns/1ns
`default_nettype none
module axil_reg_slave (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [31:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   input wire logic [31:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i,
   reg_access_if.bus regs
);
   logic aw_held_q;
   logic w_held_q;
   logic [31:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic do_write;

   // ----------------------------------------
   // Write channel
   // ----------------------------------------
   // Address and data are latched independently, in either order
   assign awready_o = !aw_held_q && !bvalid_o;
   assign wready_o = !w_held_q && !bvalid_o;
   assign do_write = aw_held_q && w_held_q && !bvalid_o;
   // Out-of-range writes answer with an error and touch no register
   assign regs.wr_en = do_write && awaddr_q[31:4] == 28'h0000000;
   assign regs.wr_addr = awaddr_q[3:0];
   assign regs.wr_data = wdata_q;
   assign regs.wr_strb = wstrb_q;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         aw_held_q <= 1'b0;
         awaddr_q <= 32'h0000_0000;
      end else if (awvalid_i && awready_o) begin
         aw_held_q <= 1'b1;
         awaddr_q <= awaddr_i;
      end else if (do_write) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         w_held_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (wvalid_i && wready_o) begin
         w_held_q <= 1'b1;
         wdata_q <= wdata_i;
         wstrb_q <= wstrb_i;
      end else if (do_write) begin
         w_held_q <= 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         bvalid_o <= 1'b0;
         bresp_o <= interval_timer_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid_o <= 1'b1;
         bresp_o <= (regs.wr_hit && awaddr_q[31:4] == 28'h0000000) ?
            interval_timer_pkg::RESP_OKAY : interval_timer_pkg::RESP_SLVERR;
      end else if (bready_i) begin
         bvalid_o <= 1'b0;
      end
   end

   // ----------------------------------------
   // Read channel
   // ----------------------------------------
   assign arready_o = !rvalid_o;
   assign regs.rd_addr = araddr_i[3:0];

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         rvalid_o <= 1'b0;
         rdata_o <= 32'h0000_0000;
         rresp_o <= interval_timer_pkg::RESP_OKAY;
      end else if (arvalid_i && arready_o) begin
         rvalid_o <= 1'b1;
         if (regs.rd_hit && araddr_i[31:4] == 28'h0000000) begin
            rdata_o <= regs.rd_data;
            rresp_o <= interval_timer_pkg::RESP_OKAY;
         end else begin
            rdata_o <= 32'h0000_0000;
            rresp_o <= interval_timer_pkg::RESP_SLVERR;
         end
      end else if (rready_i) begin
         rvalid_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: hdl/match_compare.sv */
// Equality comparator of count against compare value
`timescale 1ns/1ns
`default_nettype none
module match_compare (
   input wire logic [31:0] count_i,
   input wire logic [31:0] compare_i,
   output logic match_o
);
   assign match_o = (count_i == compare_i);
endmodule
`default_nettype wire

/* File: hdl/basic_interval_timer.sv */
// Top of the 32-bit interval timer with AXI4-Lite registers
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module basic_interval_timer (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [31:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   input wire logic [31:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i,
   output logic irq_o,
   output logic adc_trigger_o
);
   reg_access_if regs ();

   logic match_irq_enable_q;
   logic one_shot_select_q;
   logic counter_run_enable_q;
   logic match_flag_q;
   logic [31:0] count_q;
   logic [31:0] count_d;
   logic [31:0] compare_q;
   logic match;
   logic match_event;
   logic wr_ctrl;
   logic wr_status;
   logic wr_count;
   logic wr_compare;
   // Next values and helpers
   logic match_irq_enable_d;
   logic one_shot_select_d;
   logic counter_run_enable_d;
   logic match_flag_d;
   logic [31:0] compare_d;
   logic [31:0] count_plus_one;
   logic [31:0] count_step;
   logic [31:0] count_merged;
   logic [31:0] compare_merged;
   logic [31:0] ctrl_word;
   logic [31:0] status_word;
   logic ctrl_lane0;
   logic status_lane0;
   logic flag_clear;
   logic one_shot_stop;

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   axil_reg_slave u_slave (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .awaddr_i(awaddr_i),
      .awvalid_i(awvalid_i),
      .awready_o(awready_o),
      .wdata_i(wdata_i),
      .wstrb_i(wstrb_i),
      .wvalid_i(wvalid_i),
      .wready_o(wready_o),
      .bresp_o(bresp_o),
      .bvalid_o(bvalid_o),
      .bready_i(bready_i),
      .araddr_i(araddr_i),
      .arvalid_i(arvalid_i),
      .arready_o(arready_o),
      .rdata_o(rdata_o),
      .rresp_o(rresp_o),
      .rvalid_o(rvalid_o),
      .rready_i(rready_i),
      .regs(regs)
   );

   // ----------------------------------------
   // Comparator
   // ----------------------------------------
   match_compare u_cmp (
      .count_i(count_q),
      .compare_i(compare_q),
      .match_o(match)
   );

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   assign wr_ctrl = regs.wr_en && regs.wr_addr == interval_timer_pkg::CTRL_OFFSET;
   assign wr_status = regs.wr_en && regs.wr_addr == interval_timer_pkg::STATUS_OFFSET;
   assign wr_count = regs.wr_en && regs.wr_addr == interval_timer_pkg::COUNT_OFFSET;
   assign wr_compare = regs.wr_en && regs.wr_addr == interval_timer_pkg::COMPARE_OFFSET;
   assign regs.wr_hit = regs.wr_addr[1:0] == 2'h0;
   assign regs.rd_hit = regs.rd_addr[1:0] == 2'h0;
   // Control and status fields sit in byte lane 0 only
   assign ctrl_lane0 = wr_ctrl && regs.wr_strb[0];
   assign status_lane0 = wr_status && regs.wr_strb[0];

   // ----------------------------------------
   // Read words
   // ----------------------------------------
   // Unused bits read as zero
   always_comb begin
      ctrl_word = 32'h0000_0000;
      ctrl_word[interval_timer_pkg::IRQ_EN_BIT] = match_irq_enable_q;
      ctrl_word[interval_timer_pkg::ONE_SHOT_BIT] = one_shot_select_q;
      ctrl_word[interval_timer_pkg::RUN_EN_BIT] = counter_run_enable_q;
   end

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[interval_timer_pkg::FLAG_BIT] = match_flag_q;
   end

   always_comb begin
      regs.rd_data = 32'h0000_0000;
      case (regs.rd_addr)
         interval_timer_pkg::CTRL_OFFSET: regs.rd_data = ctrl_word;
         interval_timer_pkg::STATUS_OFFSET: regs.rd_data = status_word;
         interval_timer_pkg::COUNT_OFFSET: regs.rd_data = count_q;
         interval_timer_pkg::COMPARE_OFFSET: regs.rd_data = compare_q;
         default: regs.rd_data = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------
   // Match event
   // ----------------------------------------
   // Only a running counter matches, so a held equal count does not refire
   assign match_event = match && counter_run_enable_q;
   assign one_shot_stop = match_event && one_shot_select_q;
   assign flag_clear = status_lane0 && !regs.wr_data[interval_timer_pkg::FLAG_BIT];

   // ----------------------------------------
   // Byte lanes
   // ----------------------------------------
   // A written lane takes bus data, the others keep their own next value
   for (genvar lane = 0; lane < 4; lane++) begin : g_lane
      logic [7:0] count_byte;
      logic [7:0] compare_byte;
      always_comb begin
         count_byte = count_step[lane*8 +: 8];
         compare_byte = compare_q[lane*8 +: 8];
         if (regs.wr_strb[lane]) begin
            count_byte = regs.wr_data[lane*8 +: 8];
            compare_byte = regs.wr_data[lane*8 +: 8];
         end
      end
      assign count_merged[lane*8 +: 8] = count_byte;
      assign compare_merged[lane*8 +: 8] = compare_byte;
   end

   // ----------------------------------------
   // Counter step
   // ----------------------------------------
   // Reload on a match, else advance while enabled
   assign count_plus_one = count_q + 32'h0000_0001;

   always_comb begin
      count_step = count_q;
      if (match_event) begin
         count_step = 32'h0000_0000;
      end else if (counter_run_enable_q) begin
         count_step = count_plus_one;
      end
   end

   // ----------------------------------------
   // Counter load
   // ----------------------------------------
   // Written lanes override the step, so a write beats a same-cycle reload
   always_comb begin
      count_d = count_step;
      if (wr_count) begin
         count_d = count_merged;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         count_q <= interval_timer_pkg::COUNT_RESET;
      end else begin
         count_q <= count_d;
      end
   end

   // ----------------------------------------
   // Compare value
   // ----------------------------------------
   // Rewritten lane by lane like the count
   always_comb begin
      compare_d = compare_q;
      if (wr_compare) begin
         compare_d = compare_merged;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         compare_q <= interval_timer_pkg::COMPARE_RESET;
      end else begin
         compare_q <= compare_d;
      end
   end

   // ----------------------------------------
   // Interrupt enable
   // ----------------------------------------
   // Gates only the request, the flag still sets
   always_comb begin
      match_irq_enable_d = match_irq_enable_q;
      if (ctrl_lane0) begin
         match_irq_enable_d = regs.wr_data[interval_timer_pkg::IRQ_EN_BIT];
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         match_irq_enable_q <= 1'b0;
      end else begin
         match_irq_enable_q <= match_irq_enable_d;
      end
   end

   // ----------------------------------------
   // Mode select
   // ----------------------------------------
   // Zero selects repetitive mode
   always_comb begin
      one_shot_select_d = one_shot_select_q;
      if (ctrl_lane0) begin
         one_shot_select_d = regs.wr_data[interval_timer_pkg::ONE_SHOT_BIT];
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         one_shot_select_q <= 1'b0;
      end else begin
         one_shot_select_q <= one_shot_select_d;
      end
   end

   // ----------------------------------------
   // Run enable
   // ----------------------------------------
   // Software write wins over a same-cycle one-shot stop
   always_comb begin
      counter_run_enable_d = counter_run_enable_q;
      if (ctrl_lane0) begin
         counter_run_enable_d = regs.wr_data[interval_timer_pkg::RUN_EN_BIT];
      end else if (one_shot_stop) begin
         counter_run_enable_d = 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         counter_run_enable_q <= 1'b0;
      end else begin
         counter_run_enable_q <= counter_run_enable_d;
      end
   end

   // ----------------------------------------
   // Match flag
   // ----------------------------------------
   // Set wins over a same-cycle clear so no match is lost
   always_comb begin
      match_flag_d = match_flag_q;
      if (match_event) begin
         match_flag_d = 1'b1;
      end else if (flag_clear) begin
         match_flag_d = 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         match_flag_q <= 1'b0;
      end else begin
         match_flag_q <= match_flag_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Levels, held until software clears the flag; irq_o also drops when its enable is cleared
   assign irq_o = match_flag_q && match_irq_enable_q;
   assign adc_trigger_o = match_flag_q;
endmodule
`default_nettype wire

/* File: bench/basic_interval_timer_asserts.sv */
// Port checks for the interval timer
`timescale 1ns/1ns
`default_nettype none
module basic_interval_timer_asserts (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic bvalid_o,
   input wire logic [1:0] bresp_o,
   input wire logic bready_i,
   input wire logic arready_o,
   input wire logic [31:0] rdata_o,
   input wire logic [1:0] rresp_o,
   input wire logic rvalid_o,
   input wire logic rready_i,
   input wire logic irq_o,
   input wire logic adc_trigger_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   a_irq_needs_flag: assert property (irq_o |-> adc_trigger_o)
      else $error("irq high without match flag");
   a_irq_rise_cause: assert property ($rose(irq_o) && !$rose(adc_trigger_o) |-> $rose(bvalid_o))
      else $error("irq rose without flag or enable write");
   a_irq_fall_cause: assert property ($fell(irq_o) |-> $rose(bvalid_o))
      else $error("irq fell without a write");
   a_flag_sticky: assert property ($fell(adc_trigger_o) |-> $rose(bvalid_o))
      else $error("match flag cleared without a write");
   a_reset_idle: assert property (disable iff (1'b0) !rst_n_i |=> !bvalid_o && !rvalid_o && !adc_trigger_o)
      else $error("outputs active after reset");
   a_b_holds: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
      else $error("write response dropped early");
   a_r_holds: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
      else $error("read data dropped early");
   a_ar_blocked: assert property (rvalid_o |-> !arready_o)
      else $error("read address taken while answer pending");
   a_err_zero: assert property (rvalid_o && rresp_o == interval_timer_pkg::RESP_SLVERR |-> rdata_o == 32'h0)
      else $error("error read returned data");
   a_b_one_beat: assert property (bvalid_o && bready_i |=> !bvalid_o)
      else $error("write response repeated after handshake");
   a_r_one_beat: assert property (rvalid_o && rready_i |=> !rvalid_o)
      else $error("read answer repeated after handshake");
endmodule
bind basic_interval_timer basic_interval_timer_asserts u_asserts (.*);
`default_nettype wire

/* File: bench/basic_interval_timer_tb.sv */
// Self-checking bench for the interval timer
`timescale 1ns/1ns
`default_nettype none
module basic_interval_timer_tb;
   logic clock_i = 1'b0, rst_n_i = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, irq, adc;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, v;
   logic [3:0] wstrb = 4'h0;
   logic [1:0] bresp, rresp;
   logic [65:0] q[$], e;
   int failures = 0, check_count = 0, cyc = 0, seed = 32'hB661D3A4;
   always #50 clock_i = ~clock_i;
   basic_interval_timer u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .awaddr_i(awaddr),
      .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata), .wstrb_i(wstrb),
      .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid),
      .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready),
      .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready),
      .irq_o(irq), .adc_trigger_o(adc));
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
      check_count++;
      if (s !== x) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ----
   // Bus master, results noted for the watcher
   // ----
   task automatic wr(input logic [31:0] a, d, input logic [3:0] s = 4'hF, input logic [1:0] r = 2'h0);
      logic b;
      q.push_back({32'h0, 32'h0, r});
      b = 1'b1;
      @(posedge clock_i);
      awaddr <= a; wdata <= d; wstrb <= s;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      while (b) begin
         @(posedge clock_i);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            b = 1'b0;
         end
      end
   endtask
   task automatic rd(input logic [31:0] a, x, m = 32'hFFFFFFFF, input logic [1:0] r = 2'h0);
      logic b;
      q.push_back({x, m, r});
      b = 1'b1;
      @(posedge clock_i);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      while (b) begin
         @(posedge clock_i);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            rready <= 1'b0;
            b = 1'b0;
         end
      end
   endtask
   always @(posedge clock_i) begin
      if ((bvalid && bready) || (rvalid && rready)) begin
         e = q.pop_front();
         chk("resp", {30'h0, e[1:0]}, {30'h0, rvalid ? rresp : bresp});
         if (rvalid) chk("rdata", e[65:34], rdata & e[33:2]);
      end
   end
   // Ceiling well above the few hundred cycles of the sequence
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         give_verdict();
      end
   end
   initial begin
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rd(32'h0, 32'h0); rd(32'h4, 32'h0); rd(32'h8, 32'h0); rd(32'hC, 32'hFFFFFFFF);
      rd(32'h10, 32'h0, 32'hFFFFFFFF, 2'h2);
      wr(32'h10, 32'h1, 4'hF, 2'h2);
      // Out-of-range write must leave the control word alone
      rd(32'h0, 32'h0);
      $display("test reset and unmapped done");
      v = $random(seed);
      wr(32'hC, v); rd(32'hC, v);
      wr(32'h8, 32'hFFFFFFFF, 4'h3); rd(32'h8, 32'h0000FFFF);
      $display("test access done");
      wr(32'h8, 32'h0); wr(32'hC, 32'hFFFFFFFF); wr(32'h0, 32'h4);
      wr(32'h8, 32'h100);
      wr(32'h0, 32'h0);
      // Would pass 0x1FF if still counting
      repeat (300) @(posedge clock_i);
      rd(32'h8, 32'h100, 32'hFFFFFF00);
      rd(32'h4, 32'h0);
      $display("test run and stop done");
      wr(32'h8, 32'h0); wr(32'hC, 32'h3); wr(32'h0, 32'h4);
      repeat (20) @(posedge clock_i);
      rd(32'h8, 32'h0, 32'hFFFFFFFC);
      rd(32'h0, 32'h4); rd(32'h4, 32'h1);
      wr(32'h0, 32'h0); wr(32'h4, 32'h0); rd(32'h4, 32'h0);
      $display("test repetitive done");
      wr(32'h8, 32'h0);
      wr(32'hC, 32'h0);
      wr(32'h0, 32'h4);
      // Count equals compare every cycle, so the count write meets a reload
      wr(32'h8, 32'h40);
      wr(32'h0, 32'h0);
      rd(32'h8, 32'h40, 32'hFFFFFFF0);
      rd(32'h4, 32'h1);
      wr(32'h4, 32'h0);
      $display("test write over reload done");
      wr(32'h8, 32'h0); wr(32'hC, 32'h5); wr(32'h0, 32'h6);
      repeat (20) @(posedge clock_i);
      rd(32'h8, 32'h0); rd(32'h0, 32'h2); rd(32'h4, 32'h1);
      chk("irq", 32'h0, {31'h0, irq});
      chk("adc", 32'h1, {31'h0, adc});
      wr(32'h0, 32'h1);
      chk("irq", 32'h1, {31'h0, irq});
      wr(32'h4, 32'h1); rd(32'h4, 32'h1);
      wr(32'h4, 32'h0); rd(32'h4, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
      $display("test one shot and flag done");
      @(posedge clock_i);
      give_verdict();
   end
endmodule
`default_nettype wire
